// [inc/stc_pkg.sv]
package stc_pkg;

  // ****************************************
  // register map, byte addresses on the bus
  // ****************************************
  localparam logic [7:0] STC_ADR_CTRL0  = 8'h00;
  localparam logic [7:0] STC_ADR_CTRL1  = 8'h04;
  localparam logic [7:0] STC_ADR_CNT_L  = 8'h08;
  localparam logic [7:0] STC_ADR_CNT_H  = 8'h0C;
  localparam logic [7:0] STC_ADR_CMPA_L = 8'h10;
  localparam logic [7:0] STC_ADR_CMPA_H = 8'h14;
  localparam logic [7:0] STC_ADR_CMPP   = 8'h18;
  localparam logic [7:0] STC_ADR_FLAGS  = 8'h1C;

  // ****************************************
  // field encodings
  // ****************************************
  localparam logic [1:0] STC_MODE_CMP   = 2'h0;
  localparam logic [1:0] STC_MODE_UNDEF = 2'h1;
  localparam logic [1:0] STC_MODE_PWM   = 2'h2;
  localparam logic [1:0] STC_MODE_TMR   = 2'h3;
  localparam logic [1:0] STC_IO_NONE    = 2'h0;
  localparam logic [1:0] STC_IO_LOW     = 2'h1;
  localparam logic [1:0] STC_IO_HIGH    = 2'h2;
  localparam logic [1:0] STC_IO_TOGGLE  = 2'h3;
  localparam logic [1:0] STC_IO_PWM     = 2'h2;
  localparam logic [1:0] STC_IO_PULSE   = 2'h3;
  localparam logic [2:0] STC_CK_DIV4    = 3'h0;
  localparam logic [2:0] STC_CK_SYS     = 3'h1;
  localparam logic [2:0] STC_CK_DIV16   = 3'h2;
  localparam logic [2:0] STC_CK_DIV64   = 3'h3;
  localparam logic [2:0] STC_CK_SUB0    = 3'h4;
  localparam logic [2:0] STC_CK_SUB1    = 3'h5;
  localparam logic [2:0] STC_CK_EXT_R   = 3'h6;
  localparam logic [5:0] STC_PRE_DIV4   = 6'h03;
  localparam logic [5:0] STC_PRE_DIV16  = 6'h0F;
  localparam logic [5:0] STC_PRE_DIV64  = 6'h3F;
  localparam logic [15:0] STC_CNT_MAX   = 16'hFFFF;
  localparam logic [15:0] STC_CNT_ONE   = 16'h0001;
  localparam logic [16:0] STC_FULL_SPAN = 17'h1_0000;

  // ****************************************
  // register layouts
  // ****************************************
  typedef struct packed {
    logic       counter_pause;
    logic [2:0] clk_sel;
    logic       counter_on;
    logic [2:0] unused;
  } stc_ctrl0_t;

  typedef struct packed {
    logic [1:0] op_mode_sel;
    logic [1:0] pin_function_sel;
    logic       output_initial_level;
    logic       output_invert;
    logic       duty_period_swap;
    logic       clear_select;
  } stc_ctrl1_t;

  typedef struct packed {
    logic [6:0] unused;
    logic       match_p_flag;
    logic       match_a_flag;
  } stc_flags_t;

  typedef struct packed {
    logic timer_output_pin;
    logic timer_output_pin_b;
  } stc_pins_t;

endpackage : stc_pkg

// [rtl/stc_timer.sv]
// Summary of operation
// R1: counter_on rising clears the counter; falling keeps its value.
// R2: counter_on low stops counting and powers the timer down; here nothing is powered down and the prescaler keeps running.
// R3: counter_on rising restores the output to its initial level in output modes.
// R4: control register bits 2 to 0 read as zero.
// R5: mode field: 00 compare, 01 undefined, 10 PWM/pulse, 11 timer.
// R6: software turns the timer off before changing the mode field.
// R7: compare mode on A match: none, low, high or toggle.
// R8: PWM mode pin function: inactive, active, PWM, single pulse.
// R9: timer mode ignores pin function, initial level and invert bits.
// R10: compare match requesting the current level shows no change.
// R11: software changes the PWM pin function only while off.
// R12: initial level bit means start level, polarity or pulse level by mode.
// R13: invert bit inverts the output pin.
// R14: swap bit exchanges period and duty roles of A and P.
// R15: clear on A match, or on P match / overflow when P is zero.
// R16: PWM and pulse modes ignore the clear-select bit.
// R17: counter readable as two read-only bytes, zero after reset.
// R18: compare A is a 16-bit read/write value compared with all bits.
// R19: P compares with counter bits 15..8; period n*256, zero gives 65536.
// R20: compare mode, clear-select 0: both match flags raise.
// R21: compare mode, clear-select 1: only the A flag raises.
// R22: software never sets compare A to zero in compare mode.
// R23: pause freezes the counter; clearing it resumes from there.
// R24: low byte writes fill a shared buffer; high byte write loads both.
// R25: compare A zero overflows at FFFF with no A flag.
// R26: running and not paused, count one per selected timer clock edge.
//
// Design decisions made here: the register offsets and the Wishbone interface to the registers.
`timescale 1ns/1ps
`default_nettype none

module stc_timer (
  // clock and reset
  input  wire logic               SYS_CLK,
  input  wire logic               RST_N,
  // wishbone slave
  input  wire logic               CYC_I,
  input  wire logic               STB_I,
  input  wire logic               WE_I,
  input  wire logic [7:0]         ADR_I,
  input  wire logic [3:0]         SEL_I,
  input  wire logic [31:0]        DAT_I,
  output logic      [31:0]        DAT_O,
  output logic                    ACK_O,
  // timer clock sources
  input  wire logic               SUB_CLK_TICK,
  input  wire logic               TIMER_CLK_PIN,
  // outputs
  output stc_pkg::stc_pins_t      TIMER_PINS,
  output logic                    MATCH_A_FLAG,
  output logic                    MATCH_P_FLAG
);
  import stc_pkg::*;

  // ****************************************
  // state
  // ****************************************
  typedef struct packed {
    stc_ctrl0_t  c0;
    stc_ctrl1_t  c1;
    logic [15:0] cnt;
    logic [15:0] cmpa;
    logic [7:0]  cmpp;
    logic [7:0]  lbuf;
    logic        flag_a;
    logic        flag_p;
    logic        out_lvl;
    logic [5:0]  presc;
    logic        ext_prev;
    logic        ack;
    logic [31:0] dat;
    logic        pin;
    logic        pin_b;
  } stc_state_t;

  stc_state_t s_q;
  stc_state_t s_d;

  function automatic logic pre_hit(input logic [5:0] p, input logic [5:0] mask);
    pre_hit = ((p & mask) == mask);
  endfunction : pre_hit

  function automatic logic [31:0] byte_word(input logic [7:0] b);
    byte_word = {24'h00_0000, b};
  endfunction : byte_word

  // ****************************************
  // next state
  // ****************************************
  logic        tick;
  logic        run;
  logic [15:0] nxt;
  logic        a_hit;
  logic        p_hit;
  logic        is_cmp;
  logic        is_pwm;
  logic        is_pulse;
  logic        is_tmr;
  logic [16:0] duty;
  logic        pwm_act;
  logic        req;
  logic        acc;
  logic        wr0;
  logic        on_rise;
  logic [31:0] rdata;
  stc_ctrl0_t  c0_w;

  always_comb begin
    s_d      = s_q;
    s_d.presc    = s_q.presc + 6'h01;
    s_d.ext_prev = TIMER_CLK_PIN;
    case (s_q.c0.clk_sel)
      STC_CK_DIV4:  tick = pre_hit(s_q.presc, STC_PRE_DIV4);
      STC_CK_SYS:   tick = 1'b1;
      STC_CK_DIV16: tick = pre_hit(s_q.presc, STC_PRE_DIV16);
      STC_CK_DIV64: tick = pre_hit(s_q.presc, STC_PRE_DIV64);
      STC_CK_SUB0,
      STC_CK_SUB1:  tick = SUB_CLK_TICK;
      STC_CK_EXT_R: tick = TIMER_CLK_PIN & ~s_q.ext_prev;
      default:      tick = ~TIMER_CLK_PIN & s_q.ext_prev;
    endcase
    run      = s_q.c0.counter_on & ~s_q.c0.counter_pause & tick; // R2 R23 R26
    nxt      = s_q.cnt + STC_CNT_ONE;
    a_hit    = run && (s_q.cmpa != 16'h0000) && (nxt == s_q.cmpa); // R18 R25
    p_hit    = run && ((s_q.cmpp == 8'h00) ? (s_q.cnt == STC_CNT_MAX)
                                          : (nxt == {s_q.cmpp, 8'h00})); // R19
    is_cmp   = (s_q.c1.op_mode_sel == STC_MODE_CMP); // R5
    is_tmr   = (s_q.c1.op_mode_sel == STC_MODE_TMR);
    is_pwm   = (s_q.c1.op_mode_sel == STC_MODE_PWM)
               && (s_q.c1.pin_function_sel != STC_IO_PULSE);
    is_pulse = (s_q.c1.op_mode_sel == STC_MODE_PWM)
               && (s_q.c1.pin_function_sel == STC_IO_PULSE);

    // counting and clearing
    if (run) begin
      s_d.cnt = nxt; // R26
    end
    if (is_cmp || is_tmr) begin
      if (s_q.c1.clear_select ? a_hit : p_hit) begin // R15
        s_d.cnt = 16'h0000;
      end
      if (a_hit) begin
        s_d.flag_a = 1'b1; // R20 R21
      end
      if (p_hit && !s_q.c1.clear_select) begin
        s_d.flag_p = 1'b1; // R20 R21
      end
    end else if (is_pwm) begin
      // clear_select plays no part here
      if (s_q.c1.duty_period_swap ? a_hit : p_hit) begin // R14 R16
        s_d.cnt = 16'h0000;
      end
      if (a_hit) begin
        s_d.flag_a = 1'b1;
      end
      if (p_hit) begin
        s_d.flag_p = 1'b1;
      end
    end else if (is_pulse) begin
      // A match ends the pulse; counter holds until the next start
      if (a_hit) begin
        s_d.c0.counter_on = 1'b0; // R16
        s_d.flag_a        = 1'b1;
      end
    end

    // output level before polarity
    duty = s_q.c1.duty_period_swap
           ? ((s_q.cmpp == 8'h00) ? STC_FULL_SPAN : {1'b0, s_q.cmpp, 8'h00})
           : {1'b0, s_q.cmpa}; // R14
    pwm_act = ({1'b0, s_q.cnt} < duty);
    if (is_cmp && a_hit) begin
      case (s_q.c1.pin_function_sel) // R7 R10
        STC_IO_LOW:    s_d.out_lvl = 1'b0;
        STC_IO_HIGH:   s_d.out_lvl = 1'b1;
        STC_IO_TOGGLE: s_d.out_lvl = ~s_q.out_lvl;
        default:       s_d.out_lvl = s_q.out_lvl;
      endcase
    end else if (is_pwm) begin
      case (s_q.c1.pin_function_sel) // R8 R12
        STC_IO_NONE: s_d.out_lvl = ~s_q.c1.output_initial_level;
        STC_IO_LOW:  s_d.out_lvl = s_q.c1.output_initial_level;
        default:     s_d.out_lvl = pwm_act ? s_q.c1.output_initial_level
                                           : ~s_q.c1.output_initial_level;
      endcase
    end else if (is_pulse) begin
      s_d.out_lvl = s_q.c0.counter_on ? s_q.c1.output_initial_level
                                      : ~s_q.c1.output_initial_level; // R12
    end

    // ****************************************
    // bus: ack one cycle after request, effect on the ack edge
    // ****************************************
    req   = CYC_I & STB_I;
    acc   = req & s_q.ack;
    wr0   = acc & WE_I & SEL_I[0];
    s_d.ack = req & ~s_q.ack;
    case (ADR_I)
      STC_ADR_CTRL0:  rdata = byte_word({s_q.c0.counter_pause, s_q.c0.clk_sel,
                                         s_q.c0.counter_on, 3'h0}); // R4
      STC_ADR_CTRL1:  rdata = byte_word(s_q.c1);
      STC_ADR_CNT_L:  rdata = byte_word(s_q.lbuf); // R17
      STC_ADR_CNT_H:  rdata = byte_word(s_q.cnt[15:8]); // R17
      STC_ADR_CMPA_L: rdata = byte_word(s_q.lbuf);
      STC_ADR_CMPA_H: rdata = byte_word(s_q.cmpa[15:8]);
      STC_ADR_CMPP:   rdata = byte_word(s_q.cmpp);
      STC_ADR_FLAGS:  rdata = {30'h0000_0000, s_q.flag_p, s_q.flag_a};
      default:        rdata = 32'h0000_0000;
    endcase
    if (req && !s_q.ack) begin
      s_d.dat = rdata;
    end
    // reading a high byte snapshots its low byte into the shared buffer
    if (acc && !WE_I) begin
      if (ADR_I == STC_ADR_CNT_H) begin
        s_d.lbuf = s_q.cnt[7:0];
      end
      if (ADR_I == STC_ADR_CMPA_H) begin
        s_d.lbuf = s_q.cmpa[7:0];
      end
    end
    c0_w    = stc_ctrl0_t'(DAT_I[7:0]);
    on_rise = wr0 && (ADR_I == STC_ADR_CTRL0) && c0_w.counter_on
              && !s_q.c0.counter_on;
    if (wr0) begin
      case (ADR_I)
        STC_ADR_CTRL0: begin
          s_d.c0        = c0_w;
          s_d.c0.unused = 3'h0; // R4
        end
        STC_ADR_CTRL1:  s_d.c1 = stc_ctrl1_t'(DAT_I[7:0]); // R6 R11
        STC_ADR_CMPA_L: s_d.lbuf = DAT_I[7:0]; // R24
        STC_ADR_CMPA_H: s_d.cmpa = {DAT_I[7:0], s_q.lbuf}; // R24 R18 R22
        STC_ADR_CMPP:   s_d.cmpp = DAT_I[7:0];
        STC_ADR_FLAGS: begin
          // a match in the same cycle keeps its flag set
          if (DAT_I[0] && !s_d.flag_a) begin
            s_d.flag_a = 1'b0;
          end else if (DAT_I[0] && !(a_hit && (is_cmp || is_tmr || is_pwm || is_pulse))) begin
            s_d.flag_a = 1'b0;
          end
          if (DAT_I[1] && !(p_hit && !((is_cmp || is_tmr) && s_q.c1.clear_select)
                            && !is_pulse && s_q.c1.op_mode_sel != STC_MODE_UNDEF)) begin
            s_d.flag_p = 1'b0;
          end
        end
        default: ;
      endcase
    end
    if (on_rise) begin
      s_d.cnt = 16'h0000; // R1
      if (!is_tmr) begin
        s_d.out_lvl = s_d.c1.output_initial_level; // R3 R12
      end
    end

    // registered pin drive; timer mode leaves the pin parked low
    if (is_tmr) begin
      s_d.pin   = 1'b0; // R9
      s_d.pin_b = 1'b1;
    end else begin
      s_d.pin   = s_d.out_lvl ^ s_q.c1.output_invert; // R13
      s_d.pin_b = ~(s_d.out_lvl ^ s_q.c1.output_invert);
    end
  end

  // ****************************************
  // state register
  // ****************************************
  always_ff @(posedge SYS_CLK or negedge RST_N) begin
    if (!RST_N) begin
      s_q       <= '0;
      s_q.pin_b <= 1'b1;
    end else begin
      s_q <= s_d;
    end
  end

  assign DAT_O                       = s_q.dat;
  assign ACK_O                       = s_q.ack;
  assign TIMER_PINS.timer_output_pin   = s_q.pin;
  assign TIMER_PINS.timer_output_pin_b = s_q.pin_b;
  assign MATCH_A_FLAG                = s_q.flag_a;
  assign MATCH_P_FLAG                = s_q.flag_p;

  // ****************************************
  // checks
  // ****************************************
  default clocking cb @(posedge SYS_CLK); endclocking
  default disable iff (!RST_N);

  sequence seq_on_rise;
    on_rise;
  endsequence

  sequence seq_wr_low;
    wr0 && ADR_I == STC_ADR_CMPA_L;
  endsequence

  a_on_clears_cnt: assert property (seq_on_rise |=> s_q.cnt == 16'h0000) // R1
    else $error("counter not cleared on start");
  a_off_holds_cnt: assert property (!s_q.c0.counter_on && !on_rise
                                    |=> s_q.cnt == $past(s_q.cnt)) // R2
    else $error("counter moved while off");
  a_pause_freezes: assert property (s_q.c0.counter_pause && !on_rise
                                    |=> $stable(s_q.cnt)) // R23
    else $error("counter moved while paused");
  a_ctrl0_low_zero: assert property (s_q.ack && ADR_I == STC_ADR_CTRL0
                                     |-> DAT_O[2:0] == 3'h0) // R4
    else $error("unused control bits read nonzero");
  a_start_level: assert property (seq_on_rise and !is_tmr
                                  |=> s_q.out_lvl == s_q.c1.output_initial_level) // R3
    else $error("output not at initial level after start");
  // a back-to-back master leaves two idle cycles between the two ack edges
  a_cmpa_pair: assert property (seq_wr_low ##1 (!s_q.ack)[*2] ##1
                                (wr0 && ADR_I == STC_ADR_CMPA_H)
                                |=> s_q.cmpa[7:0] == $past(s_q.lbuf)) // R24
    else $error("low byte not loaded with high byte");
  a_cmpa_zero_flag: assert property (s_q.cmpa == 16'h0000 && !s_q.flag_a
                                     && !(wr0 && ADR_I == STC_ADR_CMPA_H)
                                     |=> !s_q.flag_a) // R25
    else $error("match flag raised with compare A zero");
  a_no_p_flag: assert property (is_cmp && s_q.c1.clear_select && !s_q.flag_p
                                |=> !s_q.flag_p) // R21
    else $error("P flag raised with clear on A");
  a_invert_pin: assert property (!is_tmr && !$changed(s_q.c1)
                                 && !(wr0 && ADR_I == STC_ADR_CTRL1)
                                 |=> s_q.pin == (s_q.out_lvl ^ s_q.c1.output_invert)) // R13
    else $error("pin polarity wrong");
  a_tmr_pin_idle: assert property (is_tmr |=> !s_q.pin) // R9
    else $error("pin driven in timer mode");
  a_pwm_no_clr: assert property (is_pwm && run && !s_q.c1.duty_period_swap && a_hit
                                 && !p_hit && !on_rise |=> s_q.cnt != 16'h0000) // R16
    else $error("PWM cleared by wrong comparator");
  a_ack_one: assert property (ACK_O |=> !ACK_O)
    else $error("ack held longer than one cycle");

endmodule : stc_timer

`default_nettype wire

// [bench/tb_top.sv]
`timescale 1ns/1ps
`default_nettype none

module tb_top;
  import stc_pkg::*;

  // ****************************************
  // design and stimulus signals
  // ****************************************
  logic        SYS_CLK       = 1'b0;
  logic        RST_N         = 1'b0;
  logic        CYC_I         = 1'b0;
  logic        STB_I         = 1'b0;
  logic        WE_I          = 1'b0;
  logic [7:0]  ADR_I         = 8'h00;
  logic [3:0]  SEL_I         = 4'h0;
  logic [31:0] DAT_I         = 32'h0000_0000;
  logic [31:0] DAT_O;
  logic        ACK_O;
  logic        SUB_CLK_TICK  = 1'b0;
  logic        TIMER_CLK_PIN = 1'b0;
  stc_pins_t   TIMER_PINS;
  logic        MATCH_A_FLAG;
  logic        MATCH_P_FLAG;
  int          fails         = 0;
  int          checks_done   = 0;
  logic [31:0] rs            = 32'h0000_44af;
  logic [31:0] rt            = 32'h0000_44af;
  logic [7:0]  q;
  logic [15:0] c1;
  logic [15:0] c2;
  logic        ok;
  logic        e;
  int          n;
  logic [15:0] pa [2]        = '{16'h0040, 16'h0180};
  logic [15:0] hi [2]        = '{16'h0080, 16'h0200};
  int          win [2]       = '{512, 768};

  always #4 SYS_CLK = ~SYS_CLK;

  stc_timer stc_timer_inst (
    .SYS_CLK(SYS_CLK), .RST_N(RST_N), .CYC_I(CYC_I), .STB_I(STB_I), .WE_I(WE_I),
    .ADR_I(ADR_I), .SEL_I(SEL_I), .DAT_I(DAT_I), .DAT_O(DAT_O), .ACK_O(ACK_O),
    .SUB_CLK_TICK(SUB_CLK_TICK), .TIMER_CLK_PIN(TIMER_CLK_PIN),
    .TIMER_PINS(TIMER_PINS), .MATCH_A_FLAG(MATCH_A_FLAG), .MATCH_P_FLAG(MATCH_P_FLAG));

  function automatic logic [31:0] xs(input logic [31:0] s);
    s = s ^ (s << 13);
    s = s ^ (s >> 17);
    s = s ^ (s << 5);
    return s;
  endfunction : xs

  // unused clock sources still toggle, so a wrong select shows up as odd counts
  always @(posedge SYS_CLK) begin
    rt            <= xs(rt);
    SUB_CLK_TICK  <= rt[3];
    TIMER_CLK_PIN <= rt[9];
  end

  // ****************************************
  // report and bus tasks
  // ****************************************
  task automatic wrap_up;
    if (fails == 0 && checks_done > 0) $display("ALL TESTS PASSED");
    else $display("TESTS FAILED");
    $finish;
  endtask : wrap_up

  task automatic chk(input string nm, input logic [15:0] x, input logic [15:0] g);
    checks_done++;
    if (g !== x) begin
      fails++;
      $display("BAD %s expected %h seen %h", nm, x, g);
    end
  endtask : chk

  task automatic wb(input logic we, input logic [7:0] a, input logic [7:0] d,
                    output logic [7:0] r);
    int k;
    k = 0;
    CYC_I <= 1'b1;
    STB_I <= 1'b1;
    WE_I  <= we;
    ADR_I <= a;
    SEL_I <= 4'hF;
    DAT_I <= {24'h00_0000, d};
    do begin
      @(posedge SYS_CLK);
      k++;
    end while (ACK_O !== 1'b1 && k < 64);
    r = DAT_O[7:0];
    CYC_I <= 1'b0;
    STB_I <= 1'b0;
    WE_I  <= 1'b0;
    @(posedge SYS_CLK);
    if (k >= 64) begin
      fails++;
      wrap_up();
    end
  endtask : wb

  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    logic [7:0] r;
    wb(1'b1, a, d, r);
  endtask : wr

  task automatic cnt(output logic [15:0] v);
    logic [7:0] h;
    logic [7:0] l;
    wb(1'b0, STC_ADR_CNT_H, 8'h00, h);
    wb(1'b0, STC_ADR_CNT_L, 8'h00, l);
    v = {h, l};
  endtask : cnt

  // off before any mode change, then restart from zero
  task automatic start(input logic [7:0] c, input logic [15:0] a, input logic [7:0] p);
    wr(STC_ADR_CTRL0, 8'h10);
    wr(STC_ADR_CTRL1, c);
    wr(STC_ADR_CMPA_L, a[7:0]);
    wr(STC_ADR_CMPA_H, a[15:8]);
    wr(STC_ADR_CMPP, p);
    wr(STC_ADR_FLAGS, 8'h03);
    wr(STC_ADR_CTRL0, 8'h18);
  endtask : start

  task automatic wait_flag(input logic [1:0] m, input int lim, output int k);
    k = 0;
    while (({MATCH_P_FLAG, MATCH_A_FLAG} & m) !== m && k < lim) begin
      @(posedge SYS_CLK);
      k++;
    end
    if (k >= lim) begin
      fails++;
      wrap_up();
    end
  endtask : wait_flag

  // ****************************************
  // main sequence
  // ****************************************
  initial begin
    repeat (10) @(posedge SYS_CLK);
    RST_N <= 1'b1;
    @(posedge SYS_CLK);
    for (int i = 0; i < 9; i++) begin
      wb(1'b0, 8'(i * 4), 8'h00, q);
      chk("reset value", 16'h0000, {8'h00, q});
    end
    wr(STC_ADR_CTRL0, 8'hE7);
    wb(1'b0, STC_ADR_CTRL0, 8'h00, q);
    chk("ctrl0 low bits", 16'h00E0, {8'h00, q});
    wr(STC_ADR_CTRL0, 8'h00);
    wr(STC_ADR_CNT_L, 8'h5A);
    wb(1'b0, STC_ADR_CNT_L, 8'h00, q);
    chk("count read only", 16'h0000, {8'h00, q});
    for (int i = 0; i < 4; i++) begin
      rs = xs(rs);
      wr(STC_ADR_CMPA_L, rs[7:0]);
      wr(STC_ADR_CMPA_H, rs[15:8]);
      wr(STC_ADR_CTRL1, rs[23:16]);
      wr(STC_ADR_CMPP, rs[31:24]);
      wb(1'b0, STC_ADR_CMPA_H, 8'h00, q);
      chk("cmpa high", {8'h00, rs[15:8]}, {8'h00, q});
      wb(1'b0, STC_ADR_CMPA_L, 8'h00, q);
      chk("cmpa low", {8'h00, rs[7:0]}, {8'h00, q});
      wb(1'b0, STC_ADR_CTRL1, 8'h00, q);
      chk("ctrl1", {8'h00, rs[23:16]}, {8'h00, q});
      wb(1'b0, STC_ADR_CMPP, 8'h00, q);
      chk("cmpp", {8'h00, rs[31:24]}, {8'h00, q});
    end
    wr(STC_ADR_CMPA_L, ~rs[7:0]);
    wb(1'b0, STC_ADR_CMPA_H, 8'h00, q);
    wb(1'b0, STC_ADR_CMPA_L, 8'h00, q);
    chk("low held in buffer", {8'h00, rs[7:0]}, {8'h00, q});
    // free count, divide by four, pause and restart
    start(8'hC0, 16'h0000, 8'h00);
    wr(STC_ADR_CTRL0, 8'h08);
    repeat (20) @(posedge SYS_CLK);
    wr(STC_ADR_CTRL0, 8'h88);
    cnt(c1);
    cnt(c2);
    chk("paused count", c1, c2);
    wr(STC_ADR_CTRL0, 8'h08);
    repeat (400) @(posedge SYS_CLK);
    wr(STC_ADR_CTRL0, 8'h88);
    cnt(c2);
    ok = (c2 - c1 >= 16'd99) && (c2 - c1 <= 16'd102);
    chk("ticks in 403 cycles", 16'h0001, {15'h0000, ok});
    wr(STC_ADR_CTRL0, 8'h80);
    cnt(c1);
    chk("count kept when off", c2, c1);
    wr(STC_ADR_CTRL0, 8'h08);
    cnt(c1);
    chk("count cleared on start", 16'h0001, {15'h0000, c1 < 16'h0010});
    // compare mode, clear on A, every pin function and start level
    for (int i = 0; i < 8; i++) begin
      start({2'b00, i[2:1], i[0], 3'b001}, 16'h0200, 8'h01);
      repeat (3) @(posedge SYS_CLK);
      chk("start level", {15'h0000, i[0]}, {15'h0000, TIMER_PINS.timer_output_pin});
      wait_flag(2'b01, 1200, n);
      repeat (3) @(posedge SYS_CLK);
      case (i[2:1])
        2'h0: e = i[0];
        2'h1: e = 1'b0;
        2'h2: e = 1'b1;
        default: e = ~i[0];
      endcase
      chk("match level", {15'h0000, e}, {15'h0000, TIMER_PINS.timer_output_pin});
      chk("no p flag", 16'h0000, {15'h0000, MATCH_P_FLAG});
      cnt(c1);
      chk("cleared on a", 16'h0001, {15'h0000, c1 < 16'h0040});
    end
    start(8'h00, 16'h0080, 8'h01);
    wait_flag(2'b11, 600, n);
    wb(1'b0, STC_ADR_FLAGS, 8'h00, q);
    chk("both flags", 16'h0003, {8'h00, q});
    start(8'hFC, 16'h0040, 8'h00);
    wait_flag(2'b01, 300, n);
    repeat (3) @(posedge SYS_CLK);
    chk("timer mode pin", 16'h0000, {15'h0000, TIMER_PINS.timer_output_pin});
    // single pulse: high at start, A match ends it and switches the timer off
    start(8'hB8, 16'h0040, 8'h00);
    repeat (3) @(posedge SYS_CLK);
    chk("pulse start", 16'h0001, {15'h0000, TIMER_PINS.timer_output_pin});
    wait_flag(2'b01, 300, n);
    repeat (3) @(posedge SYS_CLK);
    chk("pulse end", 16'h0000, {15'h0000, TIMER_PINS.timer_output_pin});
    wb(1'b0, STC_ADR_CTRL0, 8'h00, q);
    chk("pulse stops timer", 16'h0010, {8'h00, q});
    for (int i = 0; i < 8; i++) begin
      start({3'b100, i[0], i[1], i[2], 2'b00}, 16'h0040, 8'h01);
      repeat (4) @(posedge SYS_CLK);
      e = (i[0] ? i[1] : ~i[1]) ^ i[2];
      chk("fixed level", {15'h0000, e}, {15'h0000, TIMER_PINS.timer_output_pin});
      chk("twin pin", {15'h0000, ~e}, {15'h0000, TIMER_PINS.timer_output_pin_b});
    end
    for (int i = 0; i < 2; i++) begin
      start({6'b101010, i[0], 1'b1}, pa[i], 8'h01);
      repeat (600) @(posedge SYS_CLK);
      n = 0;
      repeat (win[i]) begin
        @(posedge SYS_CLK);
        if (TIMER_PINS.timer_output_pin === 1'b1) n++;
      end
      chk("pwm high cycles", hi[i], n[15:0]);
    end
    start(8'hC0, 16'h0000, 8'h00);
    wait_flag(2'b10, 70000, n);
    ok = (n >= 65530) && (n <= 65540);
    chk("full span", 16'h0001, {15'h0000, ok});
    chk("no a flag at zero", 16'h0000, {15'h0000, MATCH_A_FLAG});
    wrap_up();
  end

endmodule : tb_top

`default_nettype wire
